// *** rtl/eip_defs.svh ***
// Purpose: constants for the external interrupt and priority block
// Assumes: apb with 32-bit data, register index times four is the byte address
// Notes: every offset, field position, reset value and width lives here
//
// Summary of operation
// - priority register at index 0xf7, reachable from all pages, resets to zero.
// - priority bit 7 high puts the cipher interrupt at high priority; the code holds bit 7 at zero, as the writable mask is 0x0f.
// - priority bit 6 high puts the encoder interrupt at high priority; the code holds bit 6 at zero, as the writable mask is 0x0f.
// - priority bit 5 high puts the dma interrupt at high priority; the code holds bit 5 at zero, as the writable mask is 0x0f.
// - priority bit 4 high puts the pulse counter interrupt at high priority; the code holds bit 4 at zero, as the writable mask is 0x0f.
// - priority bit 3 high puts the second spi interrupt at high priority.
// - priority bit 2 high puts the oscillator fail interrupt at high priority.
// - priority bit 1 high puts the port match interrupt at high priority.
// - priority bit 0 high puts the supply warning interrupt at high priority.
// - each external input has its own active high or low polarity bit.
// - edge mode bit in timer control: one is edge, zero is level.
// - edge mode and polarity give falling, rising, low and high detection.
// - each input comes from the pin chosen in config, independent of crossbar.
// - the input logic only observes its pin, never drives it.
// - pending flags sit in timer control bit 1 and bit 3.
// - edge mode pending flag clears when the cpu vectors to the routine.
// - level mode pending flag follows the input's active level.
// - three-bit select: codes 0 to 5 port 0 pins, 6 and 7 port 1.
// - config at index 0xe4: b polarity bit 7, a polarity bit 3, selects below.
`ifndef EIP_DEFS_SVH
`define EIP_DEFS_SVH

`define EIP_ADDR_W 12
`define EIP_DATA_W 32
`define EIP_REG_W 8

// register indices, byte address is index times four
`define EIP_PRIO_IDX 10'h0f7
`define EIP_CFG_IDX 10'h0e4
`define EIP_TIMER_CONTROL_REG_IDX 10'h0c0

// reset values
`define EIP_PRIO_RST 8'h00
`define EIP_CFG_RST 8'h01
`define EIP_TIMER_CONTROL_REG_RST 8'h00

// priority register writable mask
`define EIP_PRIO_RW_MASK 8'h0f

// config fields
`define EIP_CFG_B_POL 7
`define EIP_CFG_B_SEL_HI 6
`define EIP_CFG_B_SEL_LO 4
`define EIP_CFG_A_POL 3
`define EIP_CFG_A_SEL_HI 2
`define EIP_CFG_A_SEL_LO 0

// timer control fields
`define EIP_TIMER_CONTROL_REG_A_EDGE 0
`define EIP_TIMER_CONTROL_REG_A_PEND 1
`define EIP_TIMER_CONTROL_REG_B_EDGE 2
`define EIP_TIMER_CONTROL_REG_B_PEND 3

// pin select codes from this value onward use port 1
`define EIP_SEL_PORT1_FIRST 3'h6

`endif

// *** rtl/eip_pkg.sv ***
// Purpose: types for the external interrupt and priority block
// Assumes: eip_defs.svh on the include path
// Notes: carriers for the apb request, response and block outputs
`include "eip_defs.svh"

package eip_pkg;

  typedef enum logic [1:0] {
    EIP_ST_IDLE = 2'b00,
    EIP_ST_RESP = 2'b01
  } eip_apb_st_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [`EIP_ADDR_W-1:0] paddr;
    logic [`EIP_DATA_W-1:0] pwdata;
    logic [3:0] pstrb;
  } eip_apb_req_t;

  typedef struct packed {
    logic pready;
    logic [`EIP_DATA_W-1:0] prdata;
    logic pslverr;
  } eip_apb_rsp_t;

  typedef struct packed {
    logic cipher_irq_high_prio;
    logic encoder_irq_high_prio;
    logic dma_irq_high_prio;
    logic pulse_counter_irq_high_prio;
    logic second_spi_irq_high_prio;
    logic osc_fail_irq_high_prio;
    logic port_match_irq_high_prio;
    logic supply_warning_irq_high_prio;
  } eip_prio_t;

  typedef struct packed {
    logic ext_irq_b_pending;
    logic ext_irq_a_pending;
  } eip_ext_pend_t;

endpackage

// *** rtl/eip_top.sv ***
// Purpose: priority register and two external interrupt inputs behind apb
// Assumes: port pins synchronous enough to pass two flops, one clock clk
// Notes: one wait state on every apb access
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ps
`include "eip_defs.svh"

//////////////////////////////////////////////////////////////////////////////
// one external interrupt channel
module eip_ext_chan
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [7:0] port0_in,
  input wire logic [7:0] port1_in,
  input wire logic [2:0] pin_select,
  input wire logic polarity,
  input wire logic edge_mode,
  input wire logic vector_ack,
  input wire logic sw_clear,
  output logic pending
);
  logic [2:0] sel_code;
  logic pin_sel;
  logic sync1_r;
  logic sync2_r;
  logic prev_r;
  logic pending_r;
  logic pending_nxt;
  logic cur_active;
  logic prev_active;
  logic edge_set;

  // pin choice, observe only
  assign sel_code = pin_select;
  assign pin_sel = (sel_code < `EIP_SEL_PORT1_FIRST) ? port0_in[sel_code] : port1_in[sel_code];

  // polarity folds into active level
  assign cur_active = ~(sync2_r ^ polarity);
  assign prev_active = ~(prev_r ^ polarity);
  assign edge_set = cur_active & ~prev_active;

  // set wins over clear
  assign pending_nxt = edge_mode ? (edge_set | (pending_r & ~vector_ack & ~sw_clear)) : cur_active;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      // inactive level of the reset polarity, no false request after reset
      sync1_r <= 1'b1;
      sync2_r <= 1'b1;
      prev_r <= 1'b1;
    end
    else
    begin
      sync1_r <= pin_sel;
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      pending_r <= 1'b0;
    else
      pending_r <= pending_nxt;
  end

  assign pending = pending_r;
endmodule

//////////////////////////////////////////////////////////////////////////////
// top: apb slave, registers, two channels
module eip_top
  import eip_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire eip_pkg::eip_apb_req_t apb_req,
  output eip_pkg::eip_apb_rsp_t apb_rsp,
  input wire logic [7:0] port0_in,
  input wire logic [7:0] port1_in,
  input wire logic ext_irq_a_vector_ack,
  input wire logic ext_irq_b_vector_ack,
  output eip_pkg::eip_prio_t irq_prio,
  output eip_pkg::eip_ext_pend_t ext_irq_pending
);
  import eip_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // state and registers
  eip_apb_st_t st_r;
  eip_apb_st_t st_nxt;
  logic pready_r;
  logic pslverr_r;
  logic [`EIP_DATA_W-1:0] prdata_r;
  logic [`EIP_REG_W-1:0] secondary_interrupt_priority_r;
  logic [`EIP_REG_W-1:0] ext_irq_config_r;
  logic ext_irq_a_edge_mode_r;
  logic ext_irq_b_edge_mode_r;
  logic ext_irq_a_pending;
  logic ext_irq_b_pending;

  //////////////////////////////////////////////////////////////////////////////
  // address decode
  logic access;
  logic commit;
  logic wr_commit;
  logic lane0;
  logic hit_prio;
  logic hit_cfg;
  logic hit_timer_control_reg;
  logic hit_any;
  logic [`EIP_REG_W-1:0] timer_control_reg;
  logic [`EIP_REG_W-1:0] rd_byte;
  logic [`EIP_REG_W-1:0] wbyte;
  logic a_sw_clear;
  logic b_sw_clear;

  assign access = apb_req.psel & apb_req.penable;
  assign commit = access & (st_r == EIP_ST_RESP);
  assign wr_commit = commit & apb_req.pwrite & ~pslverr_r;
  assign lane0 = apb_req.pstrb[0];
  assign wbyte = apb_req.pwdata[`EIP_REG_W-1:0];

  assign hit_prio = (apb_req.paddr == {`EIP_PRIO_IDX, 2'b00});
  assign hit_cfg = (apb_req.paddr == {`EIP_CFG_IDX, 2'b00});
  assign hit_timer_control_reg = (apb_req.paddr == {`EIP_TIMER_CONTROL_REG_IDX, 2'b00});
  assign hit_any = hit_prio | hit_cfg | hit_timer_control_reg;

  assign timer_control_reg = {4'h0, ext_irq_b_pending, ext_irq_b_edge_mode_r, ext_irq_a_pending,
    ext_irq_a_edge_mode_r};

  assign rd_byte = hit_prio ? secondary_interrupt_priority_r :
    hit_cfg ? ext_irq_config_r :
    hit_timer_control_reg ? timer_control_reg : 8'h00;

  // writing zero to a pending bit clears it in edge mode
  assign a_sw_clear = wr_commit & hit_timer_control_reg & lane0 & ~wbyte[`EIP_TIMER_CONTROL_REG_A_PEND];
  assign b_sw_clear = wr_commit & hit_timer_control_reg & lane0 & ~wbyte[`EIP_TIMER_CONTROL_REG_B_PEND];

  //////////////////////////////////////////////////////////////////////////////
  // apb handshake, one wait state
  always_comb
  begin
    case (st_r)
      EIP_ST_IDLE: st_nxt = access ? EIP_ST_RESP : EIP_ST_IDLE;
      EIP_ST_RESP: st_nxt = EIP_ST_IDLE;
      default: st_nxt = EIP_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st_r <= EIP_ST_IDLE;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end
    else
    begin
      st_r <= st_nxt;
      pready_r <= (st_nxt == EIP_ST_RESP);
      if (access && st_r == EIP_ST_IDLE)
      begin
        pslverr_r <= ~hit_any;
        prdata_r <= {24'h00_0000, rd_byte};
      end
      else if (st_r == EIP_ST_RESP)
      begin
        pslverr_r <= 1'b0;
      end
    end
  end

  assign apb_rsp.pready = pready_r;
  assign apb_rsp.pslverr = pslverr_r;
  assign apb_rsp.prdata = prdata_r;

  //////////////////////////////////////////////////////////////////////////////
  // register writes
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      secondary_interrupt_priority_r <= `EIP_PRIO_RST;
      ext_irq_config_r <= `EIP_CFG_RST;
      ext_irq_a_edge_mode_r <= 1'b0;
      ext_irq_b_edge_mode_r <= 1'b0;
    end
    else if (wr_commit && lane0)
    begin
      if (hit_prio)
        secondary_interrupt_priority_r <= (secondary_interrupt_priority_r & ~`EIP_PRIO_RW_MASK) |
          (wbyte & `EIP_PRIO_RW_MASK);
      if (hit_cfg)
        ext_irq_config_r <= wbyte;
      if (hit_timer_control_reg)
      begin
        ext_irq_a_edge_mode_r <= wbyte[`EIP_TIMER_CONTROL_REG_A_EDGE];
        ext_irq_b_edge_mode_r <= wbyte[`EIP_TIMER_CONTROL_REG_B_EDGE];
      end
    end
  end

  // priority levels straight from the register
  assign irq_prio = secondary_interrupt_priority_r;

  //////////////////////////////////////////////////////////////////////////////
  // external interrupt channels
  eip_ext_chan u_chan_a
  (
    .clk(clk),
    .nrst(nrst),
    .port0_in(port0_in),
    .port1_in(port1_in),
    .pin_select(ext_irq_config_r[`EIP_CFG_A_SEL_HI:`EIP_CFG_A_SEL_LO]),
    .polarity(ext_irq_config_r[`EIP_CFG_A_POL]),
    .edge_mode(ext_irq_a_edge_mode_r),
    .vector_ack(ext_irq_a_vector_ack),
    .sw_clear(a_sw_clear),
    .pending(ext_irq_a_pending)
  );

  eip_ext_chan u_chan_b
  (
    .clk(clk),
    .nrst(nrst),
    .port0_in(port0_in),
    .port1_in(port1_in),
    .pin_select(ext_irq_config_r[`EIP_CFG_B_SEL_HI:`EIP_CFG_B_SEL_LO]),
    .polarity(ext_irq_config_r[`EIP_CFG_B_POL]),
    .edge_mode(ext_irq_b_edge_mode_r),
    .vector_ack(ext_irq_b_vector_ack),
    .sw_clear(b_sw_clear),
    .pending(ext_irq_b_pending)
  );

  assign ext_irq_pending.ext_irq_a_pending = ext_irq_a_pending;
  assign ext_irq_pending.ext_irq_b_pending = ext_irq_b_pending;
endmodule

// *** tb/eip_asserts.sv ***
// Purpose: port checks for eip_top
// Assumes: one apb wait state
// Notes: bound into eip_top
`timescale 1ns/1ps
`include "eip_defs.svh"
module eip_asserts
  import eip_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire eip_pkg::eip_apb_req_t apb_req,
  input wire eip_pkg::eip_apb_rsp_t apb_rsp,
  input wire logic [7:0] port0_in,
  input wire logic [7:0] port1_in,
  input wire logic ext_irq_a_vector_ack,
  input wire logic ext_irq_b_vector_ack,
  input wire eip_pkg::eip_prio_t irq_prio,
  input wire eip_pkg::eip_ext_pend_t ext_irq_pending
);
  logic [15:0] pin_r;
  wire logic rdy = apb_rsp.pready;
  wire logic acc = apb_req.psel && apb_req.penable;
  wire logic [11:0] adr = apb_req.paddr;
  wire logic ev = {port1_in, port0_in} != pin_r || ext_irq_a_vector_ack || ext_irq_b_vector_ack || apb_req.psel;
  always_ff @(posedge clk)
    pin_r <= {port1_in, port0_in};
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  prio_ro_a: assert property (irq_prio[7:4] == 4'h0) else $error("prio high bits set");
  prio_wr_a: assert property (acc && rdy && apb_req.pwrite && apb_req.pstrb[0] && adr == {`EIP_PRIO_IDX, 2'b00}
    |=> irq_prio[3:0] == $past(apb_req.pwdata[3:0])) else $error("prio not written");
  wait_one_a: assert property (acc && !$past(apb_req.penable) |-> !rdy ##1 rdy) else $error("wait state");
  rdy_pulse_a: assert property (rdy |=> !rdy) else $error("ready held");
  rd_high_a: assert property (rdy |-> apb_rsp.prdata[31:8] == 24'h0) else $error("read data high");
  err_align_a: assert property (acc && rdy && adr[1:0] != 2'b00 |-> apb_rsp.pslverr) else $error("no error");
  err_map_a: assert property (acc && rdy && adr inside {{`EIP_PRIO_IDX, 2'b00}, {`EIP_CFG_IDX, 2'b00}}
    |-> !apb_rsp.pslverr) else $error("mapped error");
  pend_why_a: assert property ($changed(ext_irq_pending) |-> $past(ev, 1) || $past(ev, 2) || $past(ev, 3)
    || $past(ev, 4)) else $error("pending changed alone");
endmodule
bind eip_top eip_asserts u_eip_asserts (.clk(clk), .nrst(nrst), .apb_req(apb_req), .apb_rsp(apb_rsp),
  .port0_in(port0_in), .port1_in(port1_in), .ext_irq_a_vector_ack(ext_irq_a_vector_ack),
  .ext_irq_b_vector_ack(ext_irq_b_vector_ack), .irq_prio(irq_prio), .ext_irq_pending(ext_irq_pending));

// *** tb/eip_pins.sv ***
// Purpose: external sources on port pins
// Assumes: bench asks for pin levels
// Notes: levels change just after an edge
`timescale 1ns/1ps
module eip_pins
(
  input wire logic clk,
  input wire logic [7:0] p0_req,
  input wire logic [7:0] p1_req,
  output logic [7:0] port0_in,
  output logic [7:0] port1_in
);
  // requests held until told otherwise
  always_ff @(posedge clk)
    {port1_in, port0_in} <= {p1_req, p0_req};
endmodule

// *** tb/eip_top_bench.sv ***
// Purpose: bench for eip_top
// Assumes: eip_pins drives the pins
// Notes: pins idle high
`timescale 1ns/1ps
`include "eip_defs.svh"
`define CHK(g, x) begin comparisons++; if ((g) !== (x)) begin n_errors++; $display("Error %0t %h %h", $time, g, x); end end
module eip_top_bench;
  import eip_pkg::*;
  localparam logic [11:0] AP = {`EIP_PRIO_IDX, 2'b00};
  localparam logic [11:0] AC = {`EIP_CFG_IDX, 2'b00};
  localparam logic [11:0] AT = {`EIP_TIMER_CONTROL_REG_IDX, 2'b00};
  logic clk = 0;
  logic nrst = 0;
  logic ack_a = 0;
  logic ack_b = 0;
  logic [7:0] p0 = 8'hff;
  logic [7:0] p1 = 8'hff;
  logic [7:0] pin0, pin1;
  logic [31:0] rd;
  logic err;
  eip_apb_req_t req = '0;
  eip_apb_rsp_t rsp;
  eip_prio_t prio;
  eip_ext_pend_t pend;
  int n_errors = 0;
  int comparisons = 0;
  always #25 clk = ~clk;
  eip_pins u_eip_pins (.clk(clk), .p0_req(p0), .p1_req(p1), .port0_in(pin0), .port1_in(pin1));
  eip_top u_eip_top (.clk(clk), .nrst(nrst), .apb_req(req), .apb_rsp(rsp), .port0_in(pin0), .port1_in(pin1),
    .ext_irq_a_vector_ack(ack_a), .ext_irq_b_vector_ack(ack_b), .irq_prio(prio), .ext_irq_pending(pend));
  // ready is looked at mid-cycle, where it stands until the completing edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    req <= '{1'b1, 1'b0, w, a, {24'h0, d}, 4'h1};
    @(posedge clk);
    req.penable <= 1'b1;
    @(negedge clk);
    while (rsp.pready !== 1'b1)
      @(negedge clk);
    rd = rsp.prdata;
    err = rsp.pslverr;
    @(posedge clk);
    req <= '0;
    @(posedge clk);
  endtask
  task automatic rchk(input logic [11:0] a, input logic [7:0] x);
    apb(1'b0, a, 8'h0);
    `CHK({err, rd}, {1'b0, 24'h0, x})
  endtask
  task automatic pin_a(input logic v);
    p0[0] <= v;
    repeat (5) @(posedge clk);
  endtask
  task t_reset;
    rchk(AP, 8'h00);
    rchk(AC, 8'h01);
    rchk(AT, 8'h00);
    `CHK({prio, pend}, 10'h0)
  endtask
  task t_prio;
    for (int i = 0; i < 8; i++)
    begin
      apb(1'b1, AP, 8'h1 << i);
      `CHK(prio, (8'h1 << i) & 8'h0f)
      rchk(AP, (8'h1 << i) & 8'h0f);
    end
  endtask
  task t_bad;
    apb(1'b1, 12'h004, 8'hff);
    `CHK(err, 1'b1)
    apb(1'b0, AP + 12'h1, 8'h0);
    `CHK({err, rd}, {1'b1, 32'h0})
  endtask
  task t_modes;
    for (int m = 0; m < 4; m++)
    begin
      pin_a(~m[0]);
      apb(1'b1, AC, {4'h1, m[0], 3'h0});
      apb(1'b1, AT, {7'h0, m[1]});
      apb(1'b1, AT, {7'h0, m[1]});
      `CHK(pend[0], 1'b0)
      pin_a(m[0]);
      `CHK(pend[0], 1'b1)
      rchk(AT, {6'h0, 1'b1, m[1]});
      pin_a(~m[0]);
      `CHK(pend[0], m[1])
      ack_a <= 1'b1;
      @(posedge clk);
      ack_a <= 1'b0;
      repeat (2) @(posedge clk);
      `CHK(pend[0], 1'b0)
    end
  endtask
  task t_sel;
    apb(1'b1, AT, 8'h00);
    for (int c = 0; c < 8; c++)
    begin
      apb(1'b1, AC, {1'b1, c[2:0], 4'h8});
      {p1, p0} <= 16'h0;
      repeat (5) @(posedge clk);
      `CHK(pend, 2'b00)
      if (c < 6)
        p0[c] <= 1'b1;
      else
        p1[c] <= 1'b1;
      repeat (5) @(posedge clk);
      `CHK(pend, {1'b1, c == 0})
    end
  endtask
  task t_b_edge;
    apb(1'b1, AC, 8'h98);
    apb(1'b1, AT, 8'h04);
    `CHK(pend, 2'b00)
    p0[1] <= 1'b1;
    repeat (5) @(posedge clk);
    `CHK(pend[1], 1'b1)
    p0[1] <= 1'b0;
    repeat (5) @(posedge clk);
    `CHK(pend[1], 1'b1)
    ack_b <= 1'b1;
    @(posedge clk);
    ack_b <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK(pend[1], 1'b0)
  endtask
  task test_done;
    if (n_errors == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    #200000;
    n_errors++;
    test_done;
  end
  initial
  begin
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    t_reset;
    t_prio;
    t_bad;
    t_modes;
    t_sel;
    t_b_edge;
    test_done;
  end
endmodule
